// ### core/ssba_core.sv
/*
  Shared-SENT bus addressing and sampling for one sensor, with an
  AXI4-Lite register slave. Frame encoding and self-test live outside;
  the line input is synchronous to aclk.
*/
// What this block, the host and the integrator do
// [RQ1] With slot marking, wait 7/18/36/62 ticks by ID before frame start.
// [RQ2] Power-up offline option holds offline until sync pulse or idle sync; in addressed mode the code goes online once the line is high 2 ticks.
// [RQ3] Without it, power-up goes online with slot counter zero.
// [RQ4] Idle sync: bus high over 510 ticks clears slot counter.
// [RQ5] Addressed output sends held data if present, else fresh sample.
// [RQ6] Zero-slot option captures data on output pulse of slot zero.
// [RQ7] No-hold without zero-slot never captures; always fresh data.
// [RQ8] Sample pulse captures data unless no-hold is set.
// [RQ9] Sample pulse addresses only when sample-is-addressing is set.
// [RQ10] Integrator sets sample-addressing alike on all sensors of a bus.
// [RQ11] Sync pulse makes the next addressing pulse slot zero.
// [RQ12] Host sends ID as zero to three increment pulses, then leaves high.
// [RQ13] Addressed mode counts increments; 18 high ticks ends; reply on match.
// [RQ14] Self-test pulse: broadcast or addressed per flag; never a reply.
// [RQ15] Host starts output with function pulses and recovers from timeouts.
// [RQ16] Held data goes out on each poll until a new capture.
// [RQ17] Self-test or disabled interface discards held data.
// [RQ18] Sequential mode: count addressing pulses, reply when slot equals ID.
// [RQ19] Slot counter wraps after last index; broadcasts do not advance it.
// [RQ20] Slot marking: infer sender from high delay; mismatch goes offline.
// [RQ21] Low pulse width in ticks is classified against mode windows.
`timescale 1ns/1ps
`default_nettype none
module ssba_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ssba_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [ssba_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ssba_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [ssba_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire logic sent_line_in,
  input wire logic frame_busy,
  input wire logic [ssba_pkg::MAG_W-1:0] mag_data,
  input wire logic hall_front_self_test,
  input wire logic sent_disable,
  output logic frame_start,
  output logic frame_held,
  output logic [ssba_pkg::MAG_W-1:0] frame_data,
  output logic test_enter,
  output logic online
);
  import ssba_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    ssba_st_t st;
    ssba_ph_t ph;
    logic [1:0] slot;
    logic [2:0] idc;
    logic pdiag;
    logic mwatch;
    logic [1:0] mexp;
    logic held_v;
    logic [MAG_W-1:0] held;
    logic line;
    logic fstart;
    logic fheld;
    logic [MAG_W-1:0] fdata;
    logic tenter;
    logic online;
    logic [11:0] ctrl;
    logic [TDIV_W-1:0] tdiv;
    logic awrdy;
    logic awh;
    logic [ADDR_W-1:0] awa;
    logic wrdy;
    logic wh;
    logic [DATA_W-1:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic arrdy;
    logic rv;
    logic [DATA_W-1:0] rd;
    logic [1:0] rr;
  } ssba_regs_t;
  ssba_regs_t q, d;

  logic tick;
  logic [LOW_W-1:0] lo_cnt;
  logic [HIGH_W-1:0] hi_cnt;
  logic rise_c, fall_c, evt_c, adr, hold_ok;
  logic [1:0] dev_id, last_id;
  logic [9:0] mark_dly;
  ssba_kind_t kind;

  ssba_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(q.tdiv),
    .tick(tick)
  );

  ssba_tick_cnt #(.W(LOW_W)) u_low (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .run(~sent_line_in),
    .clr(rise_c),
    .cnt(lo_cnt)
  );

  ssba_tick_cnt #(.W(HIGH_W)) u_high (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .run(sent_line_in),
    .clr(fall_c),
    .cnt(hi_cnt)
  );

  // ************************************************************
  // Pulse classification
  // ************************************************************
  function automatic ssba_kind_t classify(input logic [LOW_W-1:0] n, input logic am);
    ssba_kind_t k;
    k = K_NONE;
    if (n >= OUT_MIN && n <= OUT_MAX) begin
      k = K_OUT;
    end else if (n >= SMP_MIN && n <= SMP_MAX) begin
      k = K_SMP;
    end else if (n >= TST_MIN && n <= TST_MAX) begin
      k = K_TEST;
    end else if (!am && n >= SYN_MIN && n <= SYN_MAX) begin
      k = K_SYNC;
    end else if (am && n >= INC_MIN && n <= INC_MAX) begin
      k = K_INC;
    end
    return k;
  endfunction

  function automatic logic [1:0] mark_id(input logic [HIGH_W-1:0] h);
    logic [1:0] r;
    r = 2'h3;
    if (h < MARK_T1) begin
      r = 2'h0;
    end else if (h < MARK_T2) begin
      r = 2'h1;
    end else if (h < MARK_T3) begin
      r = 2'h2;
    end
    return r;
  endfunction

  assign rise_c = ~q.line & sent_line_in;
  assign fall_c = q.line & ~sent_line_in;
  // Own frame pulses must not be read back as requests
  assign evt_c = rise_c & ~frame_busy & ~sent_disable & ~hall_front_self_test;
  assign kind = classify(lo_cnt, adr); // [RQ21]
  assign adr = q.ctrl[B_ADR];
  assign dev_id = q.ctrl[B_ID+:2];
  assign last_id = q.ctrl[B_LAST+:2];
  assign hold_ok = ~q.ctrl[B_NS] | q.ctrl[B_ZS];

  always_comb begin
    case (dev_id)
      2'h0: mark_dly = MARK_D0; // [RQ1]
      2'h1: mark_dly = MARK_D1;
      2'h2: mark_dly = MARK_D2;
      default: mark_dly = MARK_D3;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic rep, fire, is_addr, hit;
    rep = 1'b0;
    fire = 1'b0;
    is_addr = 1'b0;
    hit = 1'b0;
    d = q;
    d.fstart = 1'b0;
    d.tenter = 1'b0;
    d.line = sent_line_in;
    if (q.st == ST_POR) begin
      d.ph = PH_IDLE;
      d.mwatch = 1'b0;
      d.slot = 2'h0; // [RQ3]
      d.st = q.ctrl[B_POFF] ? ST_OFF : ST_ON; // [RQ2] [RQ3]
    end else if (hall_front_self_test || sent_disable) begin
      d.held_v = 1'b0; // [RQ17]
      d.st = ST_OFF;
      d.ph = PH_IDLE;
      d.mwatch = 1'b0;
    end else begin
      if (q.st == ST_OFF) begin
        if (adr) begin
          if (sent_line_in && hi_cnt >= FLUSH_TK) begin
            d.st = ST_ON;
          end
        end else if (evt_c && kind == K_SYNC) begin
          d.st = ST_ON; // [RQ2]
          d.slot = 2'h0; // [RQ11]
        end
      end else begin
        if (evt_c) begin
          if (kind == K_SMP && !q.ctrl[B_NS]) begin
            d.held_v = 1'b1; // [RQ8]
            d.held = mag_data;
          end
          if (kind == K_OUT && !adr && q.ctrl[B_ZS] && q.slot == 2'h0) begin
            d.held_v = 1'b1; // [RQ6] [RQ7]
            d.held = mag_data;
          end
          if (kind == K_SYNC) begin
            d.slot = 2'h0; // [RQ11]
          end
          if (kind == K_TEST && !q.ctrl[B_DA]) begin
            d.tenter = 1'b1; // [RQ14]
          end
          is_addr = kind == K_OUT || (kind == K_SMP && q.ctrl[B_FA]) // [RQ9]
            || (kind == K_TEST && q.ctrl[B_DA]);
          if (is_addr && !adr) begin
            hit = q.slot == dev_id; // [RQ18]
            d.slot = (q.slot == last_id) ? 2'h0 : q.slot + 2'h1; // [RQ19]
            d.mwatch = q.ctrl[B_SM];
            d.mexp = q.slot;
            if (hit && kind == K_TEST) begin
              d.tenter = 1'b1; // [RQ14]
            end else if (hit) begin
              rep = 1'b1;
            end
          end else if (is_addr) begin
            d.ph = PH_IDCNT; // [RQ13]
            d.idc = 3'h0;
            d.pdiag = kind == K_TEST;
          end
          if (kind == K_INC && q.ph == PH_IDCNT && q.idc != 3'h4) begin
            d.idc = q.idc + 3'h1; // [RQ13]
          end
        end
        if (q.ph == PH_IDCNT && sent_line_in && hi_cnt >= ID_END) begin
          d.ph = PH_IDLE; // [RQ13]
          if (q.idc == {1'b0, dev_id}) begin
            if (q.pdiag) begin
              d.tenter = 1'b1; // [RQ14]
            end else begin
              rep = 1'b1;
            end
          end
        end
        if (q.ph == PH_MARK) begin
          if (fall_c) begin
            d.ph = PH_IDLE;
          end else if (hi_cnt >= mark_dly) begin
            d.ph = PH_IDLE; // [RQ1]
            fire = 1'b1;
          end
        end
        if (rep) begin
          if (q.ctrl[B_SM] && !adr) begin
            d.ph = PH_MARK; // [RQ1]
          end else begin
            fire = 1'b1;
          end
        end
        // Any sensor may be out of step; dropping offline is the safe side
        if (q.mwatch && fall_c) begin
          d.mwatch = 1'b0;
          if (hi_cnt < MARK_WIN && mark_id(hi_cnt) != q.mexp) begin
            d.st = ST_OFF; // [RQ20]
            d.ph = PH_IDLE;
          end
        end else if (q.mwatch && hi_cnt >= MARK_WIN) begin
          d.mwatch = 1'b0;
        end
      end
      if (q.ctrl[B_IDLE] && !adr && hi_cnt > IDLE_TK) begin
        d.slot = 2'h0; // [RQ4]
        d.st = ST_ON; // [RQ2]
      end
    end
    if (fire) begin
      d.fstart = 1'b1;
      d.fheld = d.held_v; // [RQ5] [RQ16]
      d.fdata = d.held_v ? d.held : mag_data;
    end
    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    if (q.awrdy && awvalid) begin
      d.awh = 1'b1;
      d.awa = awaddr;
    end
    if (q.wrdy && wvalid) begin
      d.wh = 1'b1;
      d.wd = wdata;
      d.ws = wstrb;
    end
    if (q.bv && bready) begin
      d.bv = 1'b0;
    end
    if (d.awh && d.wh && !d.bv) begin
      d.awh = 1'b0;
      d.wh = 1'b0;
      d.bv = 1'b1;
      d.br = RESP_OK;
      case (d.awa)
        A_CTRL: begin
          if (d.ws[0]) begin
            d.ctrl[7:0] = d.wd[7:0];
          end
          if (d.ws[1]) begin
            d.ctrl[11:8] = d.wd[11:8];
            if (d.wd[B_RST]) begin
              d.st = ST_POR;
            end
          end
        end
        A_TICK: begin
          if (d.ws[0]) begin
            d.tdiv[7:0] = d.wd[7:0];
          end
          if (d.ws[1]) begin
            d.tdiv[15:8] = d.wd[15:8];
          end
        end
        A_STAT, A_HELD: d.br = RESP_OK;
        default: d.br = RESP_ERR;
      endcase
    end
    d.awrdy = !d.awh && !d.bv;
    d.wrdy = !d.wh && !d.bv;
    if (q.rv && rready) begin
      d.rv = 1'b0;
      d.arrdy = 1'b1;
    end
    if (q.arrdy && arvalid) begin
      d.rv = 1'b1;
      d.arrdy = 1'b0;
      d.rr = RESP_OK;
      d.rd = '0;
      case (araddr)
        A_CTRL: d.rd[11:0] = q.ctrl;
        A_TICK: d.rd[15:0] = q.tdiv;
        A_STAT: d.rd[10:0] = {q.mwatch, q.held_v, q.ph, q.idc, q.slot, q.st};
        A_HELD: d.rd[15:0] = q.held;
        default: d.rr = RESP_ERR;
      endcase
    end
    d.online = d.st == ST_ON;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.line <= 1'b1;
      q.ctrl <= CTRL_RST;
      q.tdiv <= TICK_RST;
      q.awrdy <= 1'b1;
      q.wrdy <= 1'b1;
      q.arrdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awrdy;
  assign wready = q.wrdy;
  assign bvalid = q.bv;
  assign bresp = q.br;
  assign arready = q.arrdy;
  assign rvalid = q.rv;
  assign rdata = q.rd;
  assign rresp = q.rr;
  assign frame_start = q.fstart;
  assign frame_held = q.fheld;
  assign frame_data = q.fdata;
  assign test_enter = q.tenter;
  assign online = q.online;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence sq_quiet;
    !hall_front_self_test && !sent_disable;
  endsequence
  sequence sq_id_done;
    q.st == ST_ON && q.ph == PH_IDCNT && sent_line_in && hi_cnt >= ID_END ##0 sq_quiet;
  endsequence
  sequence sq_evt(ssba_kind_t k);
    evt_c && q.st == ST_ON && kind == k;
  endsequence

  a_mark_fire: assert property ( // [RQ1]
    q.st == ST_ON && q.ph == PH_MARK && !fall_c && hi_cnt >= mark_dly ##0 sq_quiet
    |=> frame_start) else $error("slot mark delay did not start frame");
  a_por_offline: assert property ( // [RQ2]
    q.st == ST_POR && q.ctrl[B_POFF] |=> q.st == ST_OFF && !online)
    else $error("power-up offline not kept");
  a_por_online: assert property ( // [RQ3]
    q.st == ST_POR && !q.ctrl[B_POFF] && !hall_front_self_test && !sent_disable
    |=> online && q.slot == 2'h0) else $error("power-up not online at slot zero");
  a_idle_zero: assert property ( // [RQ4]
    q.st != ST_POR && q.ctrl[B_IDLE] && !adr && hi_cnt > IDLE_TK ##0 sq_quiet
    |=> q.slot == 2'h0 && (online || q.st == ST_POR)) else $error("idle sync did not clear slot");
  a_frame_src: assert property ( // [RQ5]
    frame_start |-> frame_held == q.held_v && (!frame_held || frame_data == q.held))
    else $error("frame data source wrong");
  a_zero_hold: assert property ( // [RQ6]
    sq_evt(K_OUT) ##0 (!adr && q.ctrl[B_ZS] && q.slot == 2'h0)
    |=> q.held_v && q.held == $past(mag_data)) else $error("zero slot capture missed");
  a_no_hold: assert property ( // [RQ7]
    $rose(q.held_v) |-> $past(hold_ok) || $past(q.ctrl[B_NS]) == 1'b0)
    else $error("capture while hold disabled");
  a_smp_hold: assert property ( // [RQ8]
    sq_evt(K_SMP) ##0 !q.ctrl[B_NS] |=> q.held_v && q.held == $past(mag_data))
    else $error("sample pulse capture missed");
  a_sync_slot: assert property ( // [RQ11]
    sq_evt(K_SYNC) |=> q.slot == 2'h0 && q.ph == PH_IDLE) else $error("sync left slot nonzero");
  a_id_reply: assert property ( // [RQ13]
    sq_id_done ##0 (adr && q.idc == {1'b0, dev_id} && !q.pdiag) |=> frame_start)
    else $error("matching ID got no frame");
  a_test_bcast: assert property ( // [RQ14]
    sq_evt(K_TEST) ##0 !q.ctrl[B_DA] |=> test_enter && !frame_start)
    else $error("broadcast self-test not entered");
  a_discard: assert property ( // [RQ17]
    q.st != ST_POR && (hall_front_self_test || sent_disable) |=> !q.held_v && !online)
    else $error("held data not discarded");
endmodule
`default_nettype wire

// ### core/ssba_pkg.sv
/*
  Shared constants for the shared-SENT addressing block: register map,
  control field positions, reset values, tick windows and state codes.
  Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package ssba_pkg;
  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MAG_W = 16;
  localparam int TDIV_W = 16;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TICK = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_HELD = 8'h0C;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Control register fields
  localparam int B_ADR = 0;
  localparam int B_POFF = 1;
  localparam int B_IDLE = 2;
  localparam int B_ZS = 3;
  localparam int B_NS = 4;
  localparam int B_FA = 5;
  localparam int B_DA = 6;
  localparam int B_SM = 7;
  localparam int B_ID = 8;
  localparam int B_LAST = 10;
  localparam int B_RST = 12;
  localparam logic [11:0] CTRL_RST = 12'hC00;
  localparam logic [15:0] TICK_RST = 16'h012C;
  // ************************************************************
  // Tick windows
  // ************************************************************
  localparam int LOW_W = 8;
  localparam int HIGH_W = 10;
  localparam logic [7:0] OUT_MIN = 8'h0F;
  localparam logic [7:0] OUT_MAX = 8'h13;
  localparam logic [7:0] SMP_MIN = 8'h1F;
  localparam logic [7:0] SMP_MAX = 8'h27;
  localparam logic [7:0] TST_MIN = 8'h38;
  localparam logic [7:0] TST_MAX = 8'h46;
  localparam logic [7:0] SYN_MIN = 8'h5D;
  localparam logic [7:0] SYN_MAX = 8'h73;
  localparam logic [7:0] INC_MIN = 8'h03;
  localparam logic [7:0] INC_MAX = 8'h0C;
  localparam logic [9:0] ID_END = 10'h012;
  localparam logic [9:0] IDLE_TK = 10'h1FE;
  localparam logic [9:0] FLUSH_TK = 10'h002;
  localparam logic [9:0] MARK_WIN = 10'h064;
  localparam logic [9:0] MARK_D0 = 10'h007;
  localparam logic [9:0] MARK_D1 = 10'h012;
  localparam logic [9:0] MARK_D2 = 10'h024;
  localparam logic [9:0] MARK_D3 = 10'h03E;
  localparam logic [9:0] MARK_T1 = 10'h00C;
  localparam logic [9:0] MARK_T2 = 10'h01B;
  localparam logic [9:0] MARK_T3 = 10'h031;
  // ************************************************************
  // State codes
  // ************************************************************
  typedef enum logic [1:0] {ST_POR = 2'b00, ST_OFF = 2'b01, ST_ON = 2'b10} ssba_st_t;
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_IDCNT = 2'b01, PH_MARK = 2'b10} ssba_ph_t;
  typedef enum logic [2:0] {
    K_NONE = 3'b000, K_OUT = 3'b001, K_SMP = 3'b010,
    K_SYNC = 3'b011, K_TEST = 3'b100, K_INC = 3'b101
  } ssba_kind_t;
endpackage
`default_nettype wire

// ### core/ssba_tick_gen.sv
/*
  SENT tick strobe: one-cycle pulse every div clocks.
  Assumes div comes from a register; 0 or 1 give a tick each clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ssba_tick_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ssba_pkg::TDIV_W-1:0] div,
  output logic tick
);
  import ssba_pkg::*;
  typedef struct packed {
    logic [TDIV_W-1:0] cnt;
    logic tick;
  } ssba_tg_t;
  ssba_tg_t q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (div <= 16'h0001 || q.cnt >= div - 16'h0001) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule
`default_nettype wire

// ### core/ssba_tick_cnt.sv
/*
  Saturating tick counter: counts ticks while run, clr has priority.
  Assumes tick is a one-cycle strobe in the aclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ssba_tick_cnt #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic clr,
  output logic [W-1:0] cnt
);
  import ssba_pkg::*;
  typedef struct packed {
    logic [W-1:0] n;
  } ssba_tc_t;
  ssba_tc_t q, d;

  always_comb begin
    d = q;
    if (clr) begin
      d.n = '0;
    end else if (run && tick && !(&q.n)) begin
      d.n = q.n + W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cnt = q.n;
endmodule
`default_nettype wire

// ### test/ssba_host_model.sv
/*
  Host model for the shared line: timed low pulses and id increments.
  Assumes the bench sets one tick per clock, so counts are clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module ssba_host_model (
  input wire logic aclk,
  output logic line
);
  // Pull-up: line idles high between pulses
  initial line = 1'h1;
  // Low for lo ticks, then released for hi ticks
  task automatic pulse(input int lo, input int hi);
    @(posedge aclk);
    line <= 1'h0;
    repeat (lo) @(posedge aclk);
    line <= 1'h1;
    repeat (hi) @(posedge aclk);
  endtask
  // Function pulse, n increments, then high past the id end
  task automatic call(input int lo, input int n);
    pulse(lo, 6);
    repeat (n) pulse(6, 6);
    repeat (30) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ### test/ssba_core_tb.sv
/*
  Self-checking bench for ssba_core: table of pulses, then hand tests.
  Assumes TICK=1 so one tick per clock; frame encoder never busy.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module ssba_core_tb;
  import ssba_pkg::*;
  typedef struct {int lo; logic [15:0] mag; int nf; logic held; logic [15:0] data;} ssba_row_t;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, hall_front_self_test = 1'h0, sent_disable = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [15:0] mag_data = 16'h0, frame_data, last_data;
  logic [1:0] bresp, rresp, rr, br;
  logic awready, wready, bvalid, arready, rvalid, frame_start, frame_held;
  logic test_enter, online, sent_line, last_held;
  int n_mismatch = 0, check_count = 0, cyc = 0, n_frame = 0, n_test = 0, f0, t0, w;
  ssba_row_t rows [8];
  always #5 aclk = ~aclk;
  ssba_core u_ssba_core (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .sent_line_in(sent_line), .frame_busy(1'h0), .mag_data, .hall_front_self_test,
    .sent_disable, .frame_start, .frame_held, .frame_data, .test_enter, .online);
  ssba_host_model u_ssba_host_model (.aclk, .line(sent_line));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Frame and self-test pulses stand one cycle: count each one
  always @(posedge aclk) begin
    cyc++;
    if (frame_start === 1'h1) begin
      n_frame++;
      last_held = frame_held;
      last_data = frame_data;
    end
    if (test_enter === 1'h1)
      n_test++;
    if (cyc > 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit aw, wd;
    aw = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw = 1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1) @(posedge aclk);
    br = bresp;
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rd = rdata;
    rr = rresp;
    rready <= 1'h0;
  endtask
  // One low pulse, then the frame count and content
  task automatic out_chk(input int lo, input int nf, input logic h, input logic [15:0] d);
    f0 = n_frame;
    u_ssba_host_model.pulse(lo, 20);
    `CHK(n_frame - f0, nf);
    if (nf == 1) begin
      `CHK(last_held, h);
      `CHK(last_data, d);
    end
  endtask
  initial begin
    // ************************************************************
    // Reset, registers, pulse table
    // ************************************************************
    rows = '{'{17, 16'hA001, 1, 1'h0, 16'hA001}, '{17, 16'hA002, 0, 1'h0, 16'h0},
      '{35, 16'hA003, 0, 1'h0, 16'h0}, '{17, 16'hA004, 0, 1'h0, 16'h0},
      '{17, 16'hA005, 0, 1'h0, 16'h0}, '{17, 16'hA006, 1, 1'h1, 16'hA003},
      '{104, 16'hA007, 0, 1'h0, 16'h0}, '{17, 16'hA008, 1, 1'h1, 16'hA003}};
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    `CHK(online, 1'h1);
    axr(A_STAT);
    `CHK(rd[3:0], 4'h2);
    axr(A_CTRL);
    `CHK(rd, 32'h00000C00);
    axr(8'h10);
    `CHK(rr, RESP_ERR);
    axw(A_TICK, 32'h1);
    `CHK(br, RESP_OK);
    axw(8'h10, 32'h1);
    `CHK(br, RESP_ERR);
    // Sample is broadcast, slot wraps after 3, sync returns to slot 0
    foreach (rows[i]) begin
      mag_data <= rows[i].mag;
      out_chk(rows[i].lo, rows[i].nf, rows[i].held, rows[i].data);
    end
    // ************************************************************
    // Discard, sampling options, sync options
    // ************************************************************
    for (int k = 0; k < 2; k++) begin
      mag_data <= 16'hB000;
      u_ssba_host_model.pulse(35, 20);
      hall_front_self_test <= (k == 0);
      sent_disable <= (k == 1);
      repeat (5) @(posedge aclk);
      hall_front_self_test <= 1'h0;
      sent_disable <= 1'h0;
      repeat (5) @(posedge aclk);
      `CHK(online, 1'h0);
      mag_data <= 16'hB100;
      u_ssba_host_model.pulse(104, 20);
      `CHK(online, 1'h1);
      out_chk(17, 1, 1'h0, 16'hB100);
    end
    axw(A_CTRL, 32'h00000C10);
    u_ssba_host_model.pulse(104, 20);
    mag_data <= 16'hC001;
    u_ssba_host_model.pulse(35, 20);
    mag_data <= 16'hC002;
    out_chk(17, 1, 1'h0, 16'hC002);
    axw(A_CTRL, 32'h00000C18);
    u_ssba_host_model.pulse(104, 20);
    mag_data <= 16'hC003;
    u_ssba_host_model.pulse(17, 20);
    axr(A_HELD);
    `CHK(rd[15:0], 16'hC003);
    axw(A_CTRL, 32'h00000C04);
    axr(A_STAT);
    `CHK(rd[3:2], 2'h1);
    repeat (530) @(posedge aclk);
    axr(A_STAT);
    `CHK(rd[3:2], 2'h0);
    // Restart with power-up offline: silent until sync
    axw(A_CTRL, 32'h00001C02);
    repeat (20) @(posedge aclk);
    `CHK(online, 1'h0);
    out_chk(17, 0, 1'h0, 16'h0);
    u_ssba_host_model.pulse(104, 20);
    `CHK(online, 1'h1);
    // Sample pulse that also addresses slot 0: held data goes out at once
    axw(A_CTRL, 32'h00000C20);
    mag_data <= 16'hD001;
    out_chk(35, 1, 1'h1, 16'hD001);
    u_ssba_host_model.pulse(104, 20);
    // Slot mark for id 0 delays the frame by about 7 ticks
    axw(A_CTRL, 32'h00000C80);
    u_ssba_host_model.pulse(17, 0);
    w = 0;
    while (frame_start !== 1'h1 && w < 100) begin
      @(posedge aclk);
      w++;
    end
    `CHK(w > 6 && w < 13, 1'h1);
    // Addressed mode, id 2; lone sensor, so sample-addressing agrees bus-wide
    axw(A_CTRL, 32'h00000E21);
    repeat (5) @(posedge aclk);
    for (int n = 0; n < 4; n++) begin
      f0 = n_frame;
      u_ssba_host_model.call(n == 3 ? 35 : 17, n == 3 ? 2 : n);
      `CHK(n_frame - f0, int'(n >= 2));
    end
    t0 = n_test;
    u_ssba_host_model.pulse(63, 30);
    `CHK(n_test - t0, 1);
    axw(A_CTRL, 32'h00000E41);
    for (int n = 1; n < 3; n++) begin
      t0 = n_test;
      f0 = n_frame;
      u_ssba_host_model.call(63, n);
      `CHK(n_test - t0, int'(n == 2));
      `CHK(n_frame - f0, 0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
